/* File: decoder_model.sv */
// decoder stand-in: barrel slot enables and return ops
`timescale 1ns/1ps
`default_nettype none
module decoder_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fast,
  input wire logic [7:0] ret_req,
  input wire logic [7:0] in_service_r,
  output logic [7:0] vector_enable,
  output logic [7:0] interrupt_return_op
);
  logic [2:0] slot_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      slot_r <= 3'h0;
      vector_enable <= 8'h00;
      interrupt_return_op <= 8'h00;
    end else begin
      slot_r <= slot_r + 3'h1;
      vector_enable <= fast ? 8'hff : 8'h01 << slot_r;
      interrupt_return_op <= ret_req & in_service_r & (8'h01 << slot_r);
    end
  end
endmodule
`default_nettype wire

/* File: thread_reset_vector_control.v */
// reset bridge, per-thread clear and interrupt vectoring with axi4-lite regs
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "thread_vector_defines.vh"
// How it works
// RULE_01: async reset pin asserts at once, releases synchronously via bridge
// RULE_02: one depth parameter sets every synchroniser length
// RULE_03: core clear pin clears per-thread state, memory untouched
// RULE_04: every cleared thread is vectored to its reset address
// RULE_05: writing ones to clear bits clears exactly those threads
// RULE_06: taking interrupt pushes pc to stack zero, loads service address
// RULE_07: only armed threads respond to interrupt requests
// RULE_08: requests ignored while the thread is in service
// RULE_09: interrupt return op resumes thread and re-enables response
// RULE_10: requests during service are dropped, never queued
// RULE_11: any thread clear disarms that thread
// RULE_12: arm write arms, disarm write disarms, last write wins
// RULE_13: simultaneous arm and disarm leaves thread disarmed
// RULE_14: zero bits in arm or disarm fields change nothing
// RULE_15: reading arm and disarm fields returns armed state
// RULE_16: external input options: resync, rising and falling detection
// RULE_17: enable is delayed one clock before use
// RULE_18: set beats reset in every set/reset flop except that disarm and clear beat arm, and clear beats the service set and pending interrupt set
// RULE_19: armed flag set by arm, reset by disarm or clear, reported
// RULE_20: pending request held until vector issued, then retired
// RULE_21: clears queued and issued by same pending and retire logic
// RULE_22: internal and external requests equal; integrator uses one per thread
// RULE_23: vector register: disarm 7-0, arm 15-8, request 23-16, clear 31-24
// RULE_24: clear takes precedence over interrupt on the same thread
// RULE_25: async reset and thread clear both force disarm
// RULE_26: vector logic replicated per thread with independent state
// RULE_27: clear drops in-service flag so thread may accept interrupts again
module thread_reset_vector_control #(
  parameter threads = `TV_THREADS,
  parameter reset_sync_depth = `TV_SYNC_DEPTH
) (
  input wire aclk,
  input wire aresetn,
  input wire core_clear_pin,
  input wire [threads-1:0] external_service_request,
  input wire [threads-1:0] interrupt_return_op,
  input wire [threads-1:0] vector_enable,
  output wire core_reset,
  output reg [threads-1:0] isr_vector_r,
  output reg [threads-1:0] clear_vector_r,
  output reg [threads-1:0] push_pc_r,
  output reg [threads-1:0] armed_r,
  output reg [threads-1:0] in_service_r,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // reset bridge: asserts with the pin, releases after the chain fills
  reg [reset_sync_depth-1:0] rst_bridge_r;
  always @(posedge aclk or negedge aresetn) begin
    if (!aresetn) begin
      rst_bridge_r <= {reset_sync_depth{1'b0}}; // RULE_01
    end else begin
      rst_bridge_r <= {rst_bridge_r[reset_sync_depth-2:0], 1'b1}; // RULE_02
    end
  end
  wire rst_n;
  assign rst_n = rst_bridge_r[reset_sync_depth-1];
  assign core_reset = ~rst_n;

  // axi4-lite write path
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg [31:0] xcfg_r;
  wire wr_fire;
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  wire aw_now;
  wire w_now;
  assign aw_now = s_axi_awvalid & s_axi_awready;
  assign w_now = s_axi_wvalid & s_axi_wready;
  wire have_aw;
  wire have_w;
  assign have_aw = aw_held_r | aw_now;
  assign have_w = w_held_r | w_now;
  assign wr_fire = have_aw & have_w;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire wr_vect;
  wire wr_xcfg;
  assign wr_vect = wr_fire & (wr_addr == `TV_VECT_OFFSET);
  assign wr_xcfg = wr_fire & (wr_addr == `TV_XCFG_OFFSET);
  wire wr_ok;
  assign wr_ok = wr_vect | wr_xcfg |
    (wr_fire & (wr_addr == `TV_STAT_OFFSET));
  // byte lanes gate each field
  wire [31:0] wr_mask;
  assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
    {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] vect_wr;
  assign vect_wr = wr_vect ? (wr_data & wr_mask) : 32'h0000_0000;
  always @(posedge aclk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TV_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `TV_RESP_OKAY : `TV_RESP_SLVERR;
      end else begin
        if (aw_now) begin
          aw_held_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
        end
        if (w_now) begin
          w_held_r <= 1'b1;
          wdata_r <= s_axi_wdata;
          wstrb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // external conditioning options register
  always @(posedge aclk) begin
    if (!rst_n) begin
      xcfg_r <= `TV_XCFG_RESET;
    end else if (wr_xcfg) begin
      xcfg_r <= (xcfg_r & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // external input conditioning, options per thread from xcfg_r
  // xcfg bits 7-0 resync, 15-8 rising edge, 23-16 falling edge
  reg [threads-1:0] xsr_sync_r [0:reset_sync_depth-1];
  reg [threads-1:0] xsr_prev_r;
  wire [threads-1:0] xsr_level;
  wire [threads-1:0] xsr_event;
  integer k;
  always @(posedge aclk) begin
    if (!rst_n) begin
      for (k = 0; k < reset_sync_depth; k = k + 1) begin
        xsr_sync_r[k] <= {threads{1'b0}};
      end
      xsr_prev_r <= {threads{1'b0}};
    end else begin
      xsr_sync_r[0] <= external_service_request;
      for (k = 1; k < reset_sync_depth; k = k + 1) begin
        xsr_sync_r[k] <= xsr_sync_r[k-1];
      end
      xsr_prev_r <= xsr_level;
    end
  end

  // core clear pin is synchronous to aclk
  wire [threads-1:0] clr_src;
  assign clr_src = vect_wr[`TV_CLR_LSB +: threads] |
    {threads{core_clear_pin}}; // RULE_03

  reg [threads-1:0] enable_d_r;
  reg [threads-1:0] isr_pend_r;
  reg [threads-1:0] clr_pend_r;
  genvar t;
  // one copy of the vector logic per thread
  generate
    for (t = 0; t < threads; t = t + 1) begin : g_thread // RULE_26
      wire res_on;
      wire rise_on;
      wire fall_on;
      wire edge_on;
      assign res_on = xcfg_r[t];
      assign rise_on = xcfg_r[8+t];
      assign fall_on = xcfg_r[16+t];
      assign edge_on = rise_on | fall_on;
      assign xsr_level[t] = res_on ?
        xsr_sync_r[reset_sync_depth-1][t] :
        external_service_request[t]; // RULE_16
      wire rise_ev;
      wire fall_ev;
      assign rise_ev = rise_on & xsr_level[t] & ~xsr_prev_r[t];
      assign fall_ev = fall_on & ~xsr_level[t] & xsr_prev_r[t];
      assign xsr_event[t] = edge_on ? (rise_ev | fall_ev) :
        xsr_level[t]; // RULE_16
      wire req;
      wire en;
      wire clr;
      wire arm_w;
      wire dis_w;
      assign req = xsr_event[t] | vect_wr[`TV_REQ_LSB+t]; // RULE_22
      assign en = enable_d_r[t]; // RULE_17
      assign clr = clr_src[t];
      assign arm_w = vect_wr[`TV_ARM_LSB+t]; // RULE_14
      assign dis_w = vect_wr[`TV_DIS_LSB+t]; // RULE_14
      wire take;
      wire isr_set;
      wire isr_retire;
      wire clr_retire;
      // vector issue: clear beats interrupt
      assign take = en & isr_pend_r[t] & ~clr_pend_r[t] & ~clr; // RULE_24
      // requests during service or a vector in flight are dropped
      assign isr_set = req & armed_r[t] & ~in_service_r[t] &
        ~isr_vector_r[t] & ~(en & isr_pend_r[t]) &
        ~clr; // RULE_07 RULE_08 RULE_10
      assign isr_retire = (en & isr_pend_r[t]) | clr |
        clr_pend_r[t]; // RULE_20 RULE_24
      assign clr_retire = en & clr_pend_r[t]; // RULE_21

      // enable delay stage
      always @(posedge aclk) begin
        if (!rst_n) begin
          enable_d_r[t] <= 1'b0;
        end else begin
          enable_d_r[t] <= vector_enable[t]; // RULE_17
        end
      end

      // armed flag: disarm and clear beat arm
      always @(posedge aclk) begin
        if (!rst_n) begin
          armed_r[t] <= 1'b0; // RULE_25
        end else if (dis_w | clr) begin
          armed_r[t] <= 1'b0; // RULE_11 RULE_13 RULE_19
        end else if (arm_w) begin
          armed_r[t] <= 1'b1; // RULE_12 RULE_19
        end
      end

      // service flag: vector issue sets, return or clear resets
      always @(posedge aclk) begin
        if (!rst_n) begin
          in_service_r[t] <= 1'b0;
        end else if (isr_vector_r[t] & ~clr_pend_r[t] & ~clr) begin
          in_service_r[t] <= 1'b1; // RULE_18
        end else if (interrupt_return_op[t] | clr) begin
          in_service_r[t] <= 1'b0; // RULE_09 RULE_27
        end
      end

      // pending interrupt: set wins over retire
      always @(posedge aclk) begin
        if (!rst_n) begin
          isr_pend_r[t] <= 1'b0;
        end else if (isr_set) begin
          isr_pend_r[t] <= 1'b1; // RULE_18 RULE_20
        end else if (isr_retire) begin
          isr_pend_r[t] <= 1'b0; // RULE_20
        end
      end

      // pending clear: same set and retire scheme
      always @(posedge aclk) begin
        if (!rst_n) begin
          clr_pend_r[t] <= 1'b0;
        end else if (clr) begin
          clr_pend_r[t] <= 1'b1; // RULE_18 RULE_21
        end else if (clr_retire) begin
          clr_pend_r[t] <= 1'b0; // RULE_21
        end
      end

      // one-cycle vector pulses to the decoder
      always @(posedge aclk) begin
        if (!rst_n) begin
          isr_vector_r[t] <= 1'b0;
          clear_vector_r[t] <= 1'b0;
          push_pc_r[t] <= 1'b0;
        end else begin
          clear_vector_r[t] <= clr_retire; // RULE_04 RULE_05
          isr_vector_r[t] <= take; // RULE_24
          push_pc_r[t] <= take; // RULE_06
        end
      end
    end
  endgenerate

  // axi4-lite read path
  assign s_axi_arready = ~s_axi_rvalid;
  wire rd_take;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  // vector register read fields
  wire [threads-1:0] rd_dis;
  wire [threads-1:0] rd_arm;
  wire [threads-1:0] rd_act;
  wire [threads-1:0] rd_clr;
  assign rd_dis = ~armed_r; // RULE_15
  assign rd_arm = armed_r; // RULE_15
  assign rd_act = in_service_r;
  assign rd_clr = clr_pend_r;
  wire [31:0] vect_rd;
  assign vect_rd = {rd_clr, rd_act, rd_arm, rd_dis}; // RULE_23
  wire [31:0] stat_rd;
  assign stat_rd = {16'h0000, isr_pend_r, enable_d_r};
  always @(posedge aclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TV_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TV_RESP_OKAY;
      case (s_axi_araddr)
        `TV_VECT_OFFSET: s_axi_rdata <= vect_rd;
        `TV_STAT_OFFSET: s_axi_rdata <= stat_rd;
        `TV_XCFG_OFFSET: s_axi_rdata <= xcfg_r;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TV_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: thread_reset_vector_control_bench.sv */
// self-checking bench for thread reset and vector control
`timescale 1ns/1ps
`default_nettype none
`include "thread_vector_defines.vh"
module thread_reset_vector_control_bench;
  logic aclk = 0, aresetn = 0, core_clear_pin = 0, fast = 0, core_reset;
  logic [7:0] external_service_request = 0, ret_req = 0;
  logic [7:0] interrupt_return_op, vector_enable, push_pc_r;
  logic [7:0] isr_vector_r, clear_vector_r, armed_r, in_service_r;
  logic [7:0] isr_seen = 0, clr_seen = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [7:0] push_seen = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int err_total = 0, check_count = 0;
  always #50 aclk = ~aclk;
  thread_reset_vector_control u_thread_reset_vector_control (.*);
  decoder_model u_decoder_model (.*);
  always @(posedge aclk) begin
    isr_seen <= isr_seen | isr_vector_r;
    clr_seen <= clr_seen | clear_vector_r;
    push_seen <= push_seen | push_pc_r;
  end
  task chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    logic aw, w, b;
    b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (b) s_axi_bready <= 0;
    end
  endtask
  task rd(input [7:0] a);
    logic ar, v;
    v = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!v) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 0;
      if (v) s_axi_rready <= 0;
    end
  endtask
  task rc(input [7:0] a, input [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task settle(input string s);
    repeat (24) @(posedge aclk);
    $display("test %s done", s);
  endtask
  task zap;
    @(negedge aclk);
    isr_seen = 0;
    clr_seen = 0;
    push_seen = 0;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    wait (!core_reset);
    rc(`TV_VECT_OFFSET, 32'h0000_00ff);
    rc(`TV_XCFG_OFFSET, `TV_XCFG_RESET);
    rd(8'h20);
    chk(r, `TV_RESP_SLVERR);
    chk(d, 32'h0000_0000);
    wr(`TV_VECT_OFFSET, 32'h0000_ff00);
    rc(`TV_VECT_OFFSET, 32'h0000_ff00);
    wr(`TV_VECT_OFFSET, 32'h0000_0301);
    rc(`TV_VECT_OFFSET, 32'h0000_fe01);
    settle("arm");
    zap;
    wr(`TV_VECT_OFFSET, 32'h0003_0000);
    settle("request");
    chk(isr_seen, 8'h02);
    chk(push_seen, 8'h02);
    rc(`TV_VECT_OFFSET, 32'h0002_fe01);
    zap;
    wr(`TV_VECT_OFFSET, 32'h0002_0000);
    ret_req <= 8'h02;
    settle("return");
    chk(in_service_r, 8'h00);
    chk(isr_seen, 8'h00);
    ret_req <= 8'h00;
    fast <= 1;
    external_service_request <= 8'h04;
    settle("external");
    chk(in_service_r, 8'h04);
    external_service_request <= 8'h00;
    zap;
    wr(`TV_VECT_OFFSET, 32'h0600_0000);
    settle("clear");
    chk(clr_seen, 8'h06);
    rc(`TV_VECT_OFFSET, 32'h0000_f807);
    fast <= 0;
    wr(`TV_VECT_OFFSET, 32'h0000_ff00);
    zap;
    @(posedge aclk);
    core_clear_pin <= 1;
    @(posedge aclk);
    core_clear_pin <= 0;
    settle("core clear");
    chk(clr_seen, 8'hff);
    rc(`TV_VECT_OFFSET, 32'h0000_00ff);
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* File: thread_vector_checker_assertions.sv */
// port checker for thread reset and vector control
`timescale 1ns/1ps
`default_nettype none
module thread_vector_checker #(parameter threads = 8) (
  input wire aclk,
  input wire core_reset,
  input wire core_clear_pin,
  input wire s_axi_wvalid,
  input wire [threads-1:0] vector_enable,
  input wire [threads-1:0] interrupt_return_op,
  input wire [threads-1:0] isr_vector_r,
  input wire [threads-1:0] clear_vector_r,
  input wire [threads-1:0] push_pc_r,
  input wire [threads-1:0] armed_r,
  input wire [threads-1:0] in_service_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (core_reset);
  property p_isr_pulse;
    isr_vector_r != 0 |=> (isr_vector_r & $past(isr_vector_r)) == 0;
  endproperty
  a_isr_pulse: assert property (p_isr_pulse)
    else $error("vector pulse longer than one cycle");
  property p_push;
    push_pc_r == isr_vector_r;
  endproperty
  a_push: assert property (p_push)
    else $error("pc push apart from vector");
  property p_serv_set;
    isr_vector_r != 0 |=> (in_service_r & $past(isr_vector_r)) == $past(isr_vector_r);
  endproperty
  a_serv_set: assert property (p_serv_set)
    else $error("service flag not set after vector");
  property p_no_nest;
    (isr_vector_r & in_service_r) == 0;
  endproperty
  a_no_nest: assert property (p_no_nest)
    else $error("vector while in service");
  property p_en_delay;
    (isr_vector_r & ~$past(vector_enable, 2)) == 0;
  endproperty
  a_en_delay: assert property (p_en_delay)
    else $error("vector without delayed enable");
  property p_clr_en;
    (clear_vector_r & ~$past(vector_enable, 2)) == 0;
  endproperty
  a_clr_en: assert property (p_clr_en)
    else $error("clear vector without delayed enable");
  property p_clr_disarm;
    core_clear_pin && !s_axi_wvalid |=> armed_r == 0;
  endproperty
  a_clr_disarm: assert property (p_clr_disarm)
    else $error("clear left a thread armed");
  property p_clr_serv;
    core_clear_pin && isr_vector_r == 0 |=> in_service_r == 0;
  endproperty
  a_clr_serv: assert property (p_clr_serv)
    else $error("clear left a thread in service");
  property p_ret;
    (interrupt_return_op & ~isr_vector_r) != 0 |=>
      (in_service_r & $past(interrupt_return_op & ~isr_vector_r)) == 0;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return left thread in service");
endmodule
bind thread_reset_vector_control thread_vector_checker #(.threads(threads))
  u_thread_vector_checker (.*);
`default_nettype wire

/* File: thread_vector_defines.vh */
// constants for the thread reset and vector control block
`ifndef THREAD_VECTOR_DEFINES_VH
`define THREAD_VECTOR_DEFINES_VH
`define TV_THREADS 8
`define TV_SYNC_DEPTH 2
`define TV_VECT_OFFSET 8'h08
`define TV_STAT_OFFSET 8'h0C
`define TV_XCFG_OFFSET 8'h10
`define TV_DIS_LSB 0
`define TV_ARM_LSB 8
`define TV_REQ_LSB 16
`define TV_CLR_LSB 24
`define TV_RESP_OKAY 2'b00
`define TV_RESP_SLVERR 2'b10
`define TV_XCFG_RESET 32'h0000_0000
`endif
